//--- core/extio_ctrl.sv
/*
  extio_ctrl.sv: control logic behind the external i/o connector: sync edge
  alignment, disable input modes, external trigger start, summary fault and
  output status pins, modulation scaling with peak clamp, apb registers and irq.
  Assumes pins are asynchronous, the nvm keeper restores the mode after power-up
  via nvm_mode/nvm_valid, and analog values arrive as signed samples on clk.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "extio_consts.svh"

module extio_ctrl
  import extio_pkg::*;
#(
  parameter int FILT = `FILT_CYC
)
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // connector pins
  input  wire logic        sync_pin,
  input  wire logic        disable_pin,
  input  wire logic        trig_pin,
  output logic             fault_pin,
  output logic             status_pin,
  // internal interfaces
  input  wire ques_ev_t    ques_ev,
  input  wire logic        oper_sum,
  input  wire logic        esr_sum,
  input  wire logic        rqs_sum,
  input  wire logic [1:0]  nvm_mode,
  input  wire logic        nvm_valid,
  output logic [1:0]       nvm_store,
  input  wire logic signed [15:0] mod_in,
  output logic signed [15:0] mod_out,
  output pin_out_t         drv,
  output logic             run_start,
  output logic             irq
);

  // two-flop synchronisers, first stage read only by second
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
    end
    else if (ce)
    begin
      s1_ff <= {trig_pin, disable_pin, sync_pin};
      s2_ff <= s1_ff;
    end
  end

  // glitch filter: level accepted only after FILT equal samples
  logic [2:0] filt_ff;
  logic [2:0] cnt_ff [3];
  logic [2:0] nxt_filt;
  logic [2:0] prev_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++)
        cnt_ff[i] <= 3'h0;
      filt_ff <= 3'h0;
      prev_ff <= 3'h0;
    end
    else if (ce)
    begin
      for (int i = 0; i < 3; i++)
        if (s2_ff[i] == filt_ff[i])
          cnt_ff[i] <= 3'h0;
        else if (cnt_ff[i] == 3'(FILT - 1))
          cnt_ff[i] <= 3'h0;
        else
          cnt_ff[i] <= cnt_ff[i] + 3'h1;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
    end
  end
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      nxt_filt[i] = (s2_ff[i] != filt_ff[i] && cnt_ff[i] == 3'(FILT - 1))
                    ? s2_ff[i] : filt_ff[i];
  end

  // edge detects on filtered pins
  wire sync_rise = filt_ff[0] & ~prev_ff[0];
  wire trig_rise = filt_ff[2] & ~prev_ff[2];

  // registers
  localparam int EV_W_C = `EV_W;
  logic [31:0] ctrl_ff;
  logic [1:0]  fsrc_ff;
  logic [EV_W_C-1:0] ist_ff;
  logic [EV_W_C-1:0] ien_ff;
  logic [15:0] gain_ff;
  logic        mode_loaded_ff;

  // apb decode
  wire acc     = psel & penable;
  wire wr      = acc & pwrite & pready; // lands only at the answer edge, never twice
  wire hit_ctl = paddr == `OFS_CTRL;
  wire hit_cmd = paddr == `OFS_CMD;
  wire hit_sta = paddr == `OFS_STATUS;
  wire hit_fs  = paddr == `OFS_FAULTSRC;
  wire hit_ist = paddr == `OFS_IRQ_STAT;
  wire hit_ien = paddr == `OFS_IRQ_EN;
  wire hit_icl = paddr == `OFS_IRQ_CLR;
  wire hit_mg  = paddr == `OFS_MOD_GAIN;
  wire hit_mc  = paddr == `OFS_MOD_CLAMP;
  wire mapped  = hit_ctl | hit_cmd | hit_sta | hit_fs | hit_ist | hit_ien | hit_icl
                 | hit_mg | hit_mc;
  wire cmd_clr  = wr & hit_cmd & pwdata[`CMD_CLEAR_BIT];
  wire cmd_go   = wr & hit_cmd & pwdata[`CMD_START_BIT];
  wire cmd_strg = wr & hit_cmd & pwdata[`CMD_SOFTTRIG];

  // config fields
  wire        pol_high  = ctrl_ff[`CTRL_POL_BIT];
  dis_mode_t  mode;
  assign mode = dis_mode_t'(ctrl_ff[`CTRL_MODE_LO +: 2]);
  wire        trig_ext  = ctrl_ff[`CTRL_TRIG_BIT];
  wire        fault_en  = ctrl_ff[`CTRL_FEN_BIT];
  wire        hi_range  = ctrl_ff[`CTRL_HIGHRANGE];
  wire        user_on   = ctrl_ff[`CTRL_USERON];

  // control register; mode restored from nvm once after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_ff        <= `CTRL_RST;
      mode_loaded_ff <= 1'b0;
      fsrc_ff        <= 2'h0;
      ien_ff         <= '0;
      gain_ff        <= 16'h0000;
    end
    else if (ce)
    begin
      if (!mode_loaded_ff && nvm_valid)
      begin
        ctrl_ff[`CTRL_MODE_LO +: 2] <= nvm_mode;
        mode_loaded_ff <= 1'b1;
      end
      else if (wr && hit_ctl)
        ctrl_ff <= {25'h0, pwdata[6:0]};
      if (wr && hit_fs)
        fsrc_ff <= pwdata[1:0];
      if (wr && hit_ien)
        ien_ff <= pwdata[EV_W_C-1:0];
      if (wr && hit_mg)
        gain_ff <= pwdata[15:0];
    end
  end

  // mode mirrored to nvm keeper so it survives power-down
  always_ff @(posedge clk)
  begin
    if (rst)
      nvm_store <= 2'b00;
    else if (ce)
      nvm_store <= ctrl_ff[`CTRL_MODE_LO +: 2];
  end

  // disable input active level per polarity
  wire dis_act = pol_high ? filt_ff[1] : ~filt_ff[1];

  // latched shutdown; set wins over clear
  logic latch_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
      latch_ff <= 1'b0;
    else if (ce)
    begin
      if (mode == MODE_LATCH && dis_act)
        latch_ff <= 1'b1;
      else if (cmd_clr)
        latch_ff <= 1'b0;
    end
  end

  // output on/off decision
  logic out_on;
  always_comb
  begin
    unique case (mode)
      MODE_FOLLOW: out_on = user_on & ~dis_act;
      MODE_LATCH:  out_on = user_on & ~latch_ff & ~dis_act;
      MODE_OFF:    out_on = user_on;
      default:     out_on = 1'b0;
    endcase
  end

  // run sequencer: arm on start, go on trigger
  run_st_t run_ff;
  run_st_t nxt_run;
  wire trig_hit = trig_ext ? trig_rise : cmd_strg;
  always_comb
  begin
    nxt_run = run_ff;
    unique case (run_ff)
      RUN_IDLE:  if (cmd_go) nxt_run = RUN_ARMED;
      RUN_ARMED: if (trig_hit) nxt_run = RUN_GO;
      RUN_GO:    nxt_run = RUN_IDLE;
      default:   nxt_run = RUN_IDLE;
    endcase
  end

  // fault summary selection
  wire ques_sum = |ques_ev;
  logic sum_sel;
  always_comb
  begin
    unique case (fault_src_t'(fsrc_ff))
      SRC_QUES: sum_sel = ques_sum;
      SRC_OPER: sum_sel = oper_sum;
      SRC_ESR:  sum_sel = esr_sum;
      SRC_RQS:  sum_sel = rqs_sum;
    endcase
  end
  wire fault_now = sum_sel & fault_en;

  // modulation: gain scaled to ten percent of full scale, then peak clamp
  function automatic logic signed [15:0] clampv(input logic signed [31:0] v,
                                                input logic signed [15:0] lim);
    if (v > 32'(lim))
      clampv = lim;
    else if (v < -32'(lim))
      clampv = -lim;
    else
      clampv = v[15:0];
  endfunction : clampv
  // 48-bit product: full-scale sample times full gain times ten overflows 32 bits
  wire signed [47:0] mod_wide = 48'(mod_in) * $signed({32'h0, gain_ff})
                                * $signed(48'(`MOD_PCT));
  wire signed [31:0] mod_prod = 32'(mod_wide / 48'sd6553600);
  wire signed [15:0] lim = hi_range ? 16'(`CLAMP_HI_DV) : 16'(`CLAMP_LO_DV);

  // pin and internal outputs, all registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_ff     <= RUN_IDLE;
      run_start  <= 1'b0;
      fault_pin  <= 1'b1;
      status_pin <= 1'b0;
      drv        <= '{relay_closed: 1'b0, setpoint_zero: 1'b1, fault_n: 1'b1,
                      sync_align: 1'b0};
      mod_out    <= 16'sh0000;
    end
    else if (ce)
    begin
      run_ff     <= nxt_run;
      run_start  <= (run_ff == RUN_ARMED) && trig_hit;
      fault_pin  <= ~fault_now;
      status_pin <= out_on;
      drv.relay_closed  <= out_on;
      drv.setpoint_zero <= ~out_on;
      drv.fault_n       <= ~fault_now;
      drv.sync_align    <= sync_rise;
      mod_out    <= clampv(mod_prod, lim);
    end
  end

  // interrupt status: set wins over clear
  wire [EV_W_C-1:0] ev = {fault_now, trig_hit, mode == MODE_LATCH && dis_act, sync_rise};
  wire [EV_W_C-1:0] clr_mask = (wr && hit_icl) ? pwdata[EV_W_C-1:0] : '0;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ist_ff <= '0;
      irq    <= 1'b0;
    end
    else if (ce)
    begin
      ist_ff <= (ist_ff & ~clr_mask) | ev;
      irq    <= |((ist_ff & ~clr_mask | ev) & ien_ff);
    end
  end

  // read mux
  wire [31:0] status_w = {26'h0, fault_now, latch_ff, run_ff, out_on, dis_act};
  wire [31:0] rd =
      hit_ctl ? ctrl_ff :
      hit_sta ? status_w :
      hit_fs  ? {30'h0, fsrc_ff} :
      hit_ist ? {28'h0, ist_ff} :
      hit_ien ? {28'h0, ien_ff} :
      hit_mg  ? {16'h0, gain_ff} :
      hit_mc  ? {16'h0, lim} : 32'h0;

  // apb answer: one wait state, error on unmapped address
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else if (ce)
    begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata  <= (acc & ~pready & ~pwrite) ? rd : 32'h0;
    end
  end

endmodule : extio_ctrl

//--- common/extio_consts.svh
/*
  extio_consts.svh: register offsets, field positions, reset values and timing counts
  for the external i/o control block (sync, disable input, trigger, fault and status pins).
  Assumes a 32-bit apb slave with word-aligned registers and a 40 MHz system clock.
*/
// How it works
// - lock generator to applied sync square wave
// - align waveform to sync rising edges only
// - default low-active disable zeroes setpoint, opens relays
// - polarity command can make high level active
// - latched mode holds shutdown until clear command
// - follow mode: output tracks disable input continuously
// - off mode ignores the disable input entirely
// - mode kept across power-down; default follow
// - trigger source internal or external, configurable
// - external trigger pulse starts an armed run
// - fault pin high when clear, low on fault
// - default fault source ORs six fault events
// - fault source selects one of four summaries
// - software enable for the fault pin
// - status pin high while output relay closed
// - modulation scales zero to ten percent full scale
// - modulated peak clamped at 485 or 242.5 volts
`ifndef EXTIO_CONSTS_SVH
`define EXTIO_CONSTS_SVH

// register byte offsets
`define OFS_CTRL      12'h000
`define OFS_CMD       12'h004
`define OFS_STATUS    12'h008
`define OFS_FAULTSRC  12'h00c
`define OFS_IRQ_STAT  12'h010
`define OFS_IRQ_EN    12'h014
`define OFS_IRQ_CLR   12'h018
`define OFS_MOD_GAIN  12'h01c
`define OFS_MOD_CLAMP 12'h020

// ctrl fields
`define CTRL_POL_BIT   0
`define CTRL_MODE_LO   1
`define CTRL_TRIG_BIT  3
`define CTRL_FEN_BIT   4
`define CTRL_HIGHRANGE 5
`define CTRL_USERON    6
`define CTRL_RST       32'h0000_0010

// cmd bits (write one to act)
`define CMD_CLEAR_BIT  0
`define CMD_START_BIT  1
`define CMD_SOFTTRIG   2

// interrupt event bits
`define EV_SYNC        0
`define EV_LATCH       1
`define EV_TRIG        2
`define EV_FAULT       3
`define EV_W           4

// modulation: ten percent of full scale, peak clamps in tenths of a volt
`define MOD_PCT        16'h000a
`define CLAMP_HI_DV    16'h12f2
`define CLAMP_LO_DV    16'h0979

// glitch filter length in cycles
`define FILT_CYC       4

`endif

//--- common/extio_pkg.sv
/*
  extio_pkg.sv: types shared by the external i/o control block.
  Assumes the constants header is included by the users of these types.
*/
package extio_pkg;

  typedef enum logic [1:0] {
    MODE_FOLLOW = 2'b00,
    MODE_LATCH  = 2'b01,
    MODE_OFF    = 2'b11
  } dis_mode_t;

  typedef enum logic [1:0] {
    SRC_QUES = 2'b00,
    SRC_OPER = 2'b01,
    SRC_ESR  = 2'b10,
    SRC_RQS  = 2'b11
  } fault_src_t;

  // run sequencer, gray along idle, armed, running
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_ARMED = 2'b01,
    RUN_GO    = 2'b11
  } run_st_t;

  typedef struct packed {
    logic bus_ov;
    logic inv_oc;
    logic inv_ot;
    logic out_ov;
    logic reg_fault;
    logic ilim_fault;
  } ques_ev_t;

  typedef struct packed {
    logic       relay_closed;
    logic       setpoint_zero;
    logic       fault_n;
    logic       sync_align;
  } pin_out_t;

endpackage : extio_pkg

//--- dv/extio_props.sv
/*
  extio_props.sv: timing checker for the external i/o control block.
  Assumes it is bound to extio_ctrl and sees only that module's ports.
*/
`timescale 1ns/100ps
`include "extio_consts.svh"
module extio_props
  import extio_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and internal outputs
  input wire logic        sync_pin,
  input wire logic        fault_pin,
  input wire logic        status_pin,
  input wire logic signed [15:0] mod_out,
  input wire pin_out_t    drv,
  input wire logic        run_start,
  input wire logic        irq
);
  logic [3:0] rise_ff;
  logic       sync_d_ff;
  // window after a sync rise; only a rise reloads it, never a fall
  always_ff @(posedge clk)
  begin
    sync_d_ff <= sync_pin;
    if (rst) rise_ff <= 4'h0;
    else if (sync_pin && !sync_d_ff) rise_ff <= 4'hf;
    else if (rise_ff != 4'h0) rise_ff <= rise_ff - 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside access phase");
  a_error_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_reset_state: assert property ($past(rst) |-> fault_pin && !status_pin && !irq)
    else $error("pins wrong after reset");
  a_status_relay: assert property (status_pin == drv.relay_closed)
    else $error("status pin differs from relay");
  a_fault_drv: assert property (fault_pin == drv.fault_n)
    else $error("fault pin differs from fault level");
  a_relay_zero: assert property (drv.relay_closed |-> !drv.setpoint_zero)
    else $error("relay closed with zero setpoint");
  a_align_rise: assert property (drv.sync_align |-> rise_ff != 4'h0)
    else $error("align without sync rise");
  a_align_pulse: assert property (drv.sync_align |=> !drv.sync_align)
    else $error("align pulse too long");
  a_mod_clamp: assert property (mod_out <= $signed(`CLAMP_HI_DV)
    && mod_out >= -$signed(`CLAMP_HI_DV))
    else $error("modulation above clamp");
  a_run_pulse: assert property (run_start |=> !run_start)
    else $error("run start too long");
  c_run: cover property (run_start);
  c_align: cover property (drv.sync_align);
  c_err: cover property (pslverr);
  c_fault: cover property (!fault_pin);
endmodule : extio_props

bind extio_ctrl extio_props extio_props_inst (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
  .fault_pin(fault_pin), .status_pin(status_pin), .mod_out(mod_out), .drv(drv),
  .run_start(run_start), .irq(irq));

//--- dv/extio_partner.sv
/*
  extio_partner.sv: outside equipment making sync square waves and trigger pulses.
  Assumes the bench drives its controls just after rising clock edges.
*/
`timescale 1ns/100ps
module extio_partner
(
  // clock and bench controls
  input  wire logic clk,
  input  wire logic sync_on,
  input  wire logic trig_req,
  // pins toward the block and rise count for the bench
  output logic      sync_pin,
  output logic      trig_pin,
  output logic [7:0] n_rise
);
  int ph = 0;
  initial
  begin
    sync_pin = 1'b0;
    trig_pin = 1'b0;
    n_rise = 8'h00;
  end
  // 12 high then 12 low; line stays low while the wave is off
  always @(posedge clk)
  begin
    // phase parked while off, so the first high never shrinks below the filter length
    ph <= (!sync_on || ph == 23) ? 0 : ph + 1;
    sync_pin <= sync_on && ph < 12;
    if (!sync_pin && sync_on && ph < 12) n_rise <= n_rise + 8'h01;
    trig_pin <= trig_req;
  end
endmodule : extio_partner

//--- dv/ext_io_inhibit_fault_status_test.sv
/*
  ext_io_inhibit_fault_status_test.sv: self-checking bench of the external i/o block.
  Assumes the partner model and the bound checker; the bench plays the nvm keeper.
*/
`timescale 1ns/100ps
`include "extio_consts.svh"
module ext_io_inhibit_fault_status_test
  import extio_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, disable_pin, sync_on, trig_req, err;
  logic sync_pin, trig_pin, fault_pin, status_pin, pready, pslverr, run_start, irq;
  logic oper_sum, esr_sum, rqs_sum;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] lfsr_ff = 32'h0000_bfbd;
  ques_ev_t ques_ev;
  logic signed [15:0] mod_in, mod_out, prev_mod;
  pin_out_t drv;
  logic [1:0] nvm_store, nvm_mode;
  logic nvm_valid;
  logic [7:0] n_rise, n_align = 8'h00, n_run = 8'h00, base;
  int miscompares = 0, n_checks = 0, cycles = 0;
  dis_mode_t md[2] = '{MODE_FOLLOW, MODE_OFF};
  extio_ctrl extio_ctrl_inst (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_pin(sync_pin), .disable_pin(disable_pin), .trig_pin(trig_pin),
    .fault_pin(fault_pin), .status_pin(status_pin), .ques_ev(ques_ev), .oper_sum(oper_sum),
    .esr_sum(esr_sum), .rqs_sum(rqs_sum), .nvm_mode(nvm_mode), .nvm_valid(nvm_valid),
    .nvm_store(nvm_store), .mod_in(mod_in), .mod_out(mod_out), .drv(drv),
    .run_start(run_start), .irq(irq));
  extio_partner extio_partner_inst (.clk(clk), .sync_on(sync_on), .trig_req(trig_req),
    .sync_pin(sync_pin), .trig_pin(trig_pin), .n_rise(n_rise));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // output on in off mode, otherwise on unless the disable input sits at its active level
  function logic exp_on(input logic [1:0] m, input logic pol, input logic pin);
    return (m == MODE_OFF) || (pin != pol);
  endfunction : exp_on
  function logic exp_flt(input logic [1:0] s, input logic en);
    logic [3:0] v;
    v = {rqs_sum, esr_sum, oper_sum, |ques_ev};
    return !(en && v[s]);
  endfunction : exp_flt
  // full gain gives ten percent of full scale, then the range clamp
  function logic [31:0] exp_mod(input logic signed [15:0] m, input logic hr);
    longint p, l;
    p = longint'(m) * 65535 * longint'(`MOD_PCT) / 6553600;
    l = hr ? `CLAMP_HI_DV : `CLAMP_LO_DV;
    if (p > l) p = l;
    if (p < -l) p = -l;
    return 32'(p);
  endfunction : exp_mod
  // monitors, hang limit and random modulation samples
  always @(posedge clk)
  begin
    lfsr_ff <= lfsr(lfsr_ff);
    mod_in <= lfsr_ff[15:0];
    prev_mod <= mod_in;
    if (drv.sync_align === 1'b1) n_align <= n_align + 8'h01;
    if (run_start === 1'b1) n_run <= n_run + 8'h01;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  task check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // one apb transfer; waits for ready with no assumed latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // pin path is two sync flops, the filter and one output flop
  task settle();
    repeat (`FILT_CYC + 8) @(posedge clk);
  endtask : settle
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sync_on, trig_req, nvm_mode, nvm_valid} = '0;
    rst = 1'b1;
    {disable_pin, ques_ev, oper_sum, esr_sum, rqs_sum} = {1'b1, 9'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, `OFS_CTRL, 0);
    check("ctrl reset", rd, `CTRL_RST);
    check("reset mode", rd[2:0], {MODE_FOLLOW, 1'b0});
    apb(0, 12'h0fc, 0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
    $display("test defaults done");
    foreach (md[i]) for (int k = 0; k < 4; k++)
    begin
      apb(1, `OFS_CTRL, 32'h50 | (md[i] << 1) | k[1]);
      disable_pin <= k[0];
      settle();
      check("status", status_pin, exp_on(md[i], k[1], k[0]));
      check("setpoint", drv.setpoint_zero, !exp_on(md[i], k[1], k[0]));
    end
    check("nvm mirror", nvm_store, MODE_OFF);
    $display("test modes done");
    apb(1, `OFS_IRQ_EN, 32'h1 << `EV_LATCH);
    apb(1, `OFS_CTRL, 32'h52);
    disable_pin <= 1'b0;
    settle();
    disable_pin <= 1'b1;
    settle();
    check("latch held", status_pin, 0);
    check("irq raised", irq, 1);
    apb(0, `OFS_IRQ_STAT, 0);
    check("irq status", rd[`EV_LATCH], 1);
    apb(1, `OFS_IRQ_EN, 0);
    settle();
    check("irq masked", irq, 0);
    apb(1, `OFS_IRQ_CLR, 32'h1 << `EV_LATCH);
    apb(1, `OFS_IRQ_EN, 32'h1 << `EV_LATCH);
    apb(1, `OFS_CMD, 32'h1 << `CMD_CLEAR_BIT);
    settle();
    check("latch clear", status_pin, 1);
    check("irq cleared", irq, 0);
    $display("test latch done");
    for (int s = 0; s < 16; s++)
    begin
      apb(1, `OFS_CTRL, 32'h40 | (s[2] << 4));
      apb(1, `OFS_FAULTSRC, s[1:0]);
      {ques_ev, oper_sum, esr_sum, rqs_sum} <= lfsr_ff[8:0];
      settle();
      check("fault pin", fault_pin, exp_flt(s[1:0], s[2]));
    end
    $display("test fault done");
    {ques_ev, oper_sum, esr_sum, rqs_sum} <= '0;
    for (int t = 0; t < 3; t++)
    begin
      base = n_run;
      apb(1, `OFS_CTRL, 32'h50 | ((t != 0) << `CTRL_TRIG_BIT));
      if (t != 2) apb(1, `OFS_CMD, 32'h1 << `CMD_START_BIT);
      if (t == 0) apb(1, `OFS_CMD, 32'h1 << `CMD_SOFTTRIG);
      trig_req <= (t != 0);
      settle();
      trig_req <= 1'b0;
      settle();
      check("run starts", n_run - base, (t != 2));
    end
    $display("test trigger done");
    sync_on <= 1'b1;
    repeat (240) @(posedge clk);
    sync_on <= 1'b0;
    settle();
    check("sync aligns", n_align, n_rise);
    check("sync rises", n_rise, 10);
    $display("test sync done");
    apb(1, `OFS_MOD_GAIN, 32'hffff);
    for (int h = 0; h < 2; h++)
    begin
      apb(1, `OFS_CTRL, 32'h50 | (h << `CTRL_HIGHRANGE));
      apb(0, `OFS_MOD_CLAMP, 0);
      check("clamp", rd, h ? `CLAMP_HI_DV : `CLAMP_LO_DV);
      repeat (16)
      begin
        @(posedge clk);
        check("mod out", mod_out, exp_mod(prev_mod, h[0]));
      end
    end
    $display("test modulation done");
    nvm_mode <= MODE_LATCH;
    nvm_valid <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, `OFS_CTRL, 0);
    check("nvm restore", rd[2:1], MODE_LATCH);
    check("nvm keep", nvm_store, MODE_LATCH);
    $display("test restore done");
    finish_test();
  end
endmodule : ext_io_inhibit_fault_status_test
